/* File: hdl/asro_pkg.sv */
// Constants, field layout and types of the sequence/result/oversampler block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package asro_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_SEQ_LEN = 12'h02C;
   localparam logic [11:0] OFS_SLOTS = 12'h034;
   localparam logic [11:0] OFS_RESULT = 12'h04C;
   localparam logic [11:0] OFS_OVS = 12'h080;
   // Field positions and widths
   localparam int SLOT_W = 5;
   localparam int SLOT_COUNT = 6;
   localparam int LEN_LSB = 20;
   localparam int PARTNER_LSB = 16;
   localparam int RES_LSB = 12;
   localparam int TRIGGERED_OVERSAMPLE_BIT = 9;
   localparam int SHIFT_LSB = 5;
   localparam int RATIO_LSB = 2;
   localparam int OVERSAMPLER_ENABLE_BIT = 0;
   localparam logic [3:0] MAX_SHIFT = 4'h8;
   localparam logic [2:0] LAST_SLOT = 3'h5;
   // Reset values
   localparam logic [31:0] RST_SEQ_LEN = 32'h0000_0000;
   localparam logic [31:0] RST_SLOTS = 32'h0000_0000;
   localparam logic [31:0] RST_RESULT = 32'h0000_0000;
   localparam logic [31:0] RST_OVS = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_TRIG, ST_START, ST_WAIT_DONE, ST_STORE
   } asro_state_t;

   // Channel held in one slot of the packed slot field
   function automatic logic [4:0] slotField(input logic [29:0] slots,
                                            input logic [2:0] idx);
      slotField = slots[idx*SLOT_W +: SLOT_W];
   endfunction

   // Keeps only the bits of the selected resolution
   function automatic logic [11:0] resMask(input logic [1:0] res);
      unique case (res)
         2'h0: resMask = 12'hFFF;
         2'h1: resMask = 12'h3FF;
         2'h2: resMask = 12'h0FF;
         2'h3: resMask = 12'h03F;
      endcase
   endfunction
endpackage

/* File: hdl/asro_acc_if.sv */
// Link between sequencer and oversampling accumulator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface asro_acc_if;
   logic clr;
   logic add;
   logic [11:0] sample;
   logic [3:0] shiftCode;
   logic [15:0] shifted;
   modport ctl (output clr, output add, output sample, output shiftCode,
                input shifted);
   modport acc (input clr, input add, input sample, input shiftCode,
                output shifted);
endinterface

/* File: hdl/asro_accum.sv */
// Oversampling accumulator with right shift of the running sum.
// Assumes clear and add never come in the same cycle.
`timescale 1ns/1ps
module asro_accum
   import asro_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Sequencer side
   asro_acc_if.acc accBus
);
   typedef struct packed {
      logic [19:0] sum;
      logic [15:0] shifted;
   } asro_acc_st_t;

   asro_acc_st_t st_reg;
   asro_acc_st_t st_next;
   logic [3:0] shiftEff;

   always_comb begin
      st_next = st_reg;
      // Reserved shift codes act as the largest legal shift
      shiftEff = (accBus.shiftCode > MAX_SHIFT) ? MAX_SHIFT : accBus.shiftCode;
      if (accBus.clr) begin
         st_next.sum = '0;
      end else if (accBus.add) begin
         st_next.sum = st_reg.sum + 20'(accBus.sample);
      end
      // 20-bit sum holds 256 samples of 12 bits without overflow
      st_next.shifted = 16'(st_next.sum >> shiftEff);
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign accBus.shifted = st_reg.shifted;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_acc_clear: assert property (accBus.clr |=> st_reg.sum == 20'h00000)
      else $error("accumulator not cleared");
   a_shift_zero: assert property (
      accBus.shiftCode == 4'h0 && !accBus.add && !accBus.clr
      |=> st_reg.shifted == st_reg.sum[15:0])
      else $error("zero shift altered the sum");
endmodule // asro_accum

/* File: hdl/asro_top.sv */
// Routine sequencer, result register and oversampler controls over APB.
// Assumes the converter core, triggers and partner run on core_clk.
`timescale 1ns/1ps
module asro_top
   import asro_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter state and trigger
   input wire logic converterOn,
   input wire logic convTrigger,
   // Converter core
   output logic convStart,
   output logic [4:0] convChannel,
   output logic [1:0] resolutionSelect,
   input wire logic convDone,
   input wire logic [11:0] convData,
   // Partner converter in synchronous mode
   input wire logic syncMode,
   input wire logic partnerValid,
   input wire logic [15:0] partnerConverterResult,
   // Status
   output logic sequenceDone
);
   typedef struct packed {
      asro_state_t state;
      logic [29:0] slots;
      logic [3:0] sequenceLength;
      logic [1:0] resSel;
      logic triggeredOversample;
      logic [3:0] shift;
      logic [2:0] oversampleRatio;
      logic oversamplerEnable;
      logic [15:0] resultLo;
      logic [15:0] resultHi;
      logic [2:0] slot;
      logic [4:0] chan;
      logic [8:0] sampleCnt;
      logic [31:0] rdata;
      logic seqDone;
   } asro_top_st_t;

   asro_top_st_t st_reg;
   asro_top_st_t st_next;
   asro_acc_if accBus();
   logic wrAccess;
   logic setupPhase;
   logic [8:0] sampleTarget;
   logic [8:0] cntInc;
   logic [2:0] lastSlot;
   logic moreSamples;

   function automatic logic isMapped(input logic [11:0] addr);
      isMapped = (addr == OFS_SEQ_LEN) || (addr == OFS_SLOTS) ||
                 (addr == OFS_RESULT) || (addr == OFS_OVS);
   endfunction

   asro_accum u_accum (
      .core_clk(core_clk),
      .resetn(resetn),
      .accBus(accBus)
   );

   assign setupPhase = psel && !penable;
   // Unmapped or misaligned word addresses write nothing
   assign wrAccess = psel && penable && pwrite && isMapped(paddr);
   // Ratio code k gives 2 << k samples, one when oversampler is off
   assign sampleTarget = st_reg.oversamplerEnable ?
                         (9'h002 << st_reg.oversampleRatio) : 9'h001;
   assign cntInc = st_reg.sampleCnt + 9'h001;
   assign moreSamples = cntInc < sampleTarget;
   // Only six slots exist here, so longer sequences stop at the sixth
   assign lastSlot = (st_reg.sequenceLength > 4'(LAST_SLOT)) ?
                     LAST_SLOT : st_reg.sequenceLength[2:0];

   always_comb begin
      st_next = st_reg;
      st_next.seqDone = 1'b0;
      accBus.clr = 1'b0;
      accBus.add = 1'b0;
      accBus.sample = convData & resMask(st_reg.resSel);
      accBus.shiftCode = st_reg.oversamplerEnable ? st_reg.shift : 4'h0;

      // Read data latched in the setup phase
      if (setupPhase) begin
         unique case (paddr)
            OFS_SEQ_LEN:
               st_next.rdata = 32'(st_reg.sequenceLength) << LEN_LSB;
            OFS_SLOTS: st_next.rdata = {2'h0, st_reg.slots};
            OFS_RESULT: st_next.rdata = {st_reg.resultHi, st_reg.resultLo};
            OFS_OVS: st_next.rdata = {18'h00000, st_reg.resSel, 2'h0,
                                      st_reg.triggeredOversample, st_reg.shift,
                                      st_reg.oversampleRatio, 1'h0,
                                      st_reg.oversamplerEnable};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end

      // Writes; the result register ignores them
      if (wrAccess) begin
         unique case (paddr)
            OFS_SEQ_LEN:
               st_next.sequenceLength = pwdata[LEN_LSB +: 4];
            OFS_SLOTS: st_next.slots = pwdata[29:0];
            OFS_OVS: begin
               st_next.resSel = pwdata[RES_LSB +: 2];
               if (!converterOn) begin
                  st_next.triggeredOversample = pwdata[TRIGGERED_OVERSAMPLE_BIT];
                  st_next.shift = pwdata[SHIFT_LSB +: 4];
                  st_next.oversampleRatio = pwdata[RATIO_LSB +: 3];
                  st_next.oversamplerEnable = pwdata[OVERSAMPLER_ENABLE_BIT];
               end
            end
            default: ;
         endcase
      end

      // Partner result exists only on the first instance
      if (FIRST_INSTANCE && syncMode && partnerValid) begin
         st_next.resultHi = partnerConverterResult;
      end

      unique case (st_reg.state)
         ST_IDLE: begin
            if (convTrigger) begin
               st_next.slot = 3'h0;
               st_next.sampleCnt = 9'h000;
               st_next.chan = slotField(st_reg.slots, 3'h0);
               st_next.state = ST_START;
            end
         end
         ST_WAIT_TRIG: begin
            if (convTrigger) begin
               st_next.state = ST_START;
            end
         end
         ST_START: begin
            accBus.clr = (st_reg.sampleCnt == 9'h000);
            st_next.state = ST_WAIT_DONE;
         end
         ST_WAIT_DONE: begin
            if (convDone) begin
               accBus.add = 1'b1;
               st_next.sampleCnt = cntInc;
               if (!moreSamples) begin
                  st_next.state = ST_STORE;
               end else if (st_reg.triggeredOversample) begin
                  st_next.state = ST_WAIT_TRIG;
               end else begin
                  st_next.state = ST_START;
               end
            end
         end
         ST_STORE: begin
            st_next.resultLo = accBus.shifted;
            st_next.sampleCnt = 9'h000;
            if (st_reg.slot == lastSlot) begin
               st_next.seqDone = 1'b1;
               st_next.state = ST_IDLE;
            end else begin
               st_next.slot = st_reg.slot + 3'h1;
               st_next.chan = slotField(st_reg.slots, st_reg.slot + 3'h1);
               st_next.state = ST_START;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.sequenceLength <= RST_SEQ_LEN[LEN_LSB +: 4];
         st_reg.slots <= RST_SLOTS[29:0];
         st_reg.resultLo <= RST_RESULT[15:0];
         st_reg.resultHi <= RST_RESULT[31:16];
         st_reg.oversamplerEnable <= RST_OVS[OVERSAMPLER_ENABLE_BIT];
      end else begin
         st_reg <= st_next;
      end
   end

   // Zero-wait slave; word accesses only, no byte lanes exist
   assign pready = psel && penable;
   assign pslverr = psel && penable && !isMapped(paddr);
   assign prdata = st_reg.rdata;
   assign convStart = (st_reg.state == ST_START);
   assign convChannel = st_reg.chan;
   assign resolutionSelect = st_reg.resSel;
   assign sequenceDone = st_reg.seqDone;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_slot_channel: assert property (
      convStart && $stable(st_reg.slots)
      |-> convChannel == slotField(st_reg.slots, st_reg.slot))
      else $error("channel differs from current slot");
   a_seq_length: assert property (
      sequenceDone |-> $past(st_reg.slot) == lastSlot)
      else $error("sequence ended at wrong slot");
   a_result_readonly: assert property (
      wrAccess && paddr == OFS_RESULT && st_reg.state != ST_STORE
      |=> $stable(st_reg.resultLo))
      else $error("write changed result");
   a_partner_upper: assert property (
      FIRST_INSTANCE && syncMode && partnerValid
      |=> st_reg.resultHi == $past(partnerConverterResult))
      else $error("partner result not captured");
   a_resolution_mask: assert property (
      st_reg.state == ST_STORE && !st_reg.oversamplerEnable
      |=> (st_reg.resultLo[11:0] & ~resMask(st_reg.resSel)) == 12'h000)
      else $error("result wider than resolution");
   a_back_to_back: assert property (
      st_reg.state == ST_WAIT_DONE && convDone && moreSamples &&
      !st_reg.triggeredOversample |=> convStart)
      else $error("untriggered oversample stalled");
   a_trigger_wait: assert property (
      st_reg.state == ST_WAIT_TRIG && !convTrigger
      |=> !convStart ##0 st_reg.state == ST_WAIT_TRIG)
      else $error("conversion without trigger");
   a_ratio_count: assert property (
      st_reg.state == ST_STORE && st_reg.oversamplerEnable
      |-> st_reg.sampleCnt == (9'h002 << st_reg.oversampleRatio))
      else $error("wrong number of samples");
   a_enable_write: assert property (
      wrAccess && paddr == OFS_OVS && !converterOn
      |=> st_reg.oversamplerEnable == $past(pwdata[OVERSAMPLER_ENABLE_BIT]))
      else $error("enable write lost");
   a_lock_on: assert property (
      wrAccess && paddr == OFS_OVS && converterOn
      |=> $stable(st_reg.oversamplerEnable) && $stable(st_reg.shift) &&
          $stable(st_reg.oversampleRatio) &&
          $stable(st_reg.triggeredOversample))
      else $error("locked field changed");
   a_store_shift: assert property (
      st_reg.state == ST_STORE |=> st_reg.resultLo == $past(accBus.shifted))
      else $error("shifted sum not stored");
   a_start_pulse: assert property (
      convStart
      |=> !convStart)
      else $error("start wider than one cycle");
   a_chan_hold: assert property (
      st_reg.state == ST_WAIT_DONE
      |-> $stable(convChannel))
      else $error("channel moved during conversion");
   a_slot_write: assert property (
      wrAccess && paddr == OFS_SLOTS
      |=> st_reg.slots == $past(pwdata[29:0]))
      else $error("slot write lost");
   a_len_write: assert property (
      wrAccess && paddr == OFS_SEQ_LEN
      |=> st_reg.sequenceLength == $past(pwdata[LEN_LSB +: 4]))
      else $error("length write lost");
   a_idle_trigger: assert property (
      st_reg.state == ST_IDLE && convTrigger
      |=> convStart && st_reg.slot == 3'h0)
      else $error("sequence did not start at first slot");
   a_next_slot: assert property (
      st_reg.state == ST_STORE && st_reg.slot != lastSlot
      |=> convStart && st_reg.slot == $past(st_reg.slot) + 3'h1)
      else $error("slot order broken");
   a_done_pulse: assert property (
      sequenceDone
      |=> !sequenceDone)
      else $error("done wider than one cycle");
   a_res_write: assert property (
      wrAccess && paddr == OFS_OVS
      |=> resolutionSelect == $past(pwdata[RES_LSB +: 2]))
      else $error("resolution write lost");
   a_no_stray_start: assert property (
      st_reg.state == ST_WAIT_DONE && !convDone
      |=> !convStart)
      else $error("start while conversion busy");
   a_single_sample: assert property (
      st_reg.state == ST_WAIT_DONE && convDone && !st_reg.oversamplerEnable
      |=> st_reg.state == ST_STORE)
      else $error("extra sample with oversampler off");
   a_unmapped_write: assert property (
      psel && penable && pwrite && !isMapped(paddr)
      |=> $stable(st_reg.slots) && $stable(st_reg.sequenceLength))
      else $error("unmapped write changed a register");
   a_first_clear: assert property (
      st_reg.state == ST_START && st_reg.sampleCnt == 9'h000
      |-> accBus.clr)
      else $error("accumulator not cleared at first sample");

   c_sequence_done: cover property (sequenceDone);
   c_ovs_store: cover property (
      st_reg.state == ST_STORE && st_reg.oversamplerEnable);
   c_trig_wait: cover property (st_reg.state == ST_WAIT_TRIG ##1 convStart);
   c_slave_error: cover property (pslverr);
   c_partner_sync: cover property (syncMode && partnerValid);
endmodule // asro_top

/* File: test/asro_core_model.sv */
// Behavioural converter core: answers each start with one sample.
// Assumes convStart is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module asro_core_model #(
   parameter int LAT = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Converter core
   input wire logic convStart,
   input wire logic [4:0] convChannel,
   output logic convDone,
   output logic [11:0] convData
);
   int cnt = 0;
   logic [4:0] ch = 5'h00;
   initial begin
      convDone = 1'b0;
      convData = 12'h000;
   end
   always @(posedge core_clk) begin
      convDone <= 1'b0;
      // Data only valid with done, so scramble it afterwards
      if (convDone) convData <= ~convData;
      if (!resetn) cnt <= 0;
      else if (convStart === 1'b1) begin
         ch <= convChannel;
         cnt <= LAT;
      end else if (cnt == 1) begin
         convDone <= 1'b1;
         convData <= {ch, 7'h55};
         cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
   end
endmodule // asro_core_model

/* File: test/asro_tb_top.sv */
// Self-checking bench: APB register traffic and conversion sequences.
// Assumes zero-wait APB slave and the core model in test/.
`timescale 1ns/1ps
module asro_tb_top;
   import asro_pkg::*;
   logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, convStart, convDone, sequenceDone, err;
   logic converterOn = 0, convTrigger = 0, syncMode = 0, partnerValid = 0;
   logic [4:0] convChannel;
   logic [1:0] resolutionSelect;
   logic [11:0] convData;
   logic [15:0] partnerConverterResult = 16'h0;
   int fails = 0, tests_run = 0, starts = 0;
   logic [4:0] chans[$];
   logic [4:0] expCh[3] = '{5'h03, 5'h11, 5'h09};

   always #5 core_clk = ~core_clk;

   asro_top i_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .converterOn(converterOn), .convTrigger(convTrigger),
      .convStart(convStart), .convChannel(convChannel),
      .resolutionSelect(resolutionSelect), .convDone(convDone),
      .convData(convData), .syncMode(syncMode),
      .partnerValid(partnerValid),
      .partnerConverterResult(partnerConverterResult),
      .sequenceDone(sequenceDone));
   asro_core_model i_core (.core_clk(core_clk), .resetn(resetn),
      .convStart(convStart), .convChannel(convChannel),
      .convDone(convDone), .convData(convData));

   // Sampled mid-cycle so the state update has landed
   always @(negedge core_clk) begin
      if (convStart === 1'b1) begin
         starts++;
         chans.push_back(convChannel);
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic trig();
      @(posedge core_clk);
      convTrigger <= 1'b1;
      @(posedge core_clk);
      convTrigger <= 1'b0;
   endtask

   task automatic waitDone();
      int n;
      n = 0;
      while (sequenceDone !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 500) fails++;
      chk(32'h1, {31'h0, sequenceDone});
   endtask

   // Expected masked sample, worked out independently of the design
   function automatic logic [31:0] smp(input logic [4:0] ch,
                                       input logic [1:0] res);
      smp = {20'h0, {ch, 7'h55} & (12'hFFF >> (2 * res))};
   endfunction

   task automatic finish_test();
      $display("Checks %0d, errors %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      finish_test();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      apb(0, OFS_SLOTS, 0); chk(RST_SLOTS, rd);
      apb(0, OFS_RESULT, 0); chk(RST_RESULT, rd);
      apb(0, OFS_OVS, 0); chk(RST_OVS, rd);
      apb(0, 12'h010, 0); chk(32'h1, {31'h0, err});
      apb(1, OFS_SLOTS, 32'h0B00_A623);
      apb(0, OFS_SLOTS, 0); chk(32'h0B00_A623, rd);
      apb(1, OFS_SEQ_LEN, 32'h0020_0000);
      starts = 0;
      chans.delete();
      trig();
      waitDone();
      chk(3, starts);
      for (int i = 0; i < 3; i++) chk({27'h0, expCh[i]}, {27'h0, chans[i]});
      apb(0, OFS_RESULT, 0); chk(smp(5'h09, 2'h0), rd);
      // Untriggered 4x, shift 1, 10-bit resolution, one slot
      apb(1, OFS_SEQ_LEN, 32'h0);
      apb(1, OFS_OVS, 32'h0000_1025);
      // Register output settles after the commit edge
      @(negedge core_clk);
      chk(32'h1, {30'h0, resolutionSelect});
      starts = 0;
      trig();
      waitDone();
      chk(4, starts);
      apb(0, OFS_RESULT, 0); chk((smp(5'h03, 2'h1) * 4) >> 1, rd);
      // Triggered 2x: one start per trigger
      apb(1, OFS_OVS, 32'h0000_0221);
      starts = 0;
      trig();
      repeat (20) @(posedge core_clk);
      chk(1, starts);
      trig();
      waitDone();
      chk(2, starts);
      apb(0, OFS_RESULT, 0); chk(smp(5'h03, 2'h0), rd);
      apb(1, OFS_RESULT, 32'hFFFF_FFFF);
      apb(0, OFS_RESULT, 0); chk(smp(5'h03, 2'h0), rd);
      // Converter on: only resolution may change
      converterOn <= 1'b1;
      apb(1, OFS_OVS, 32'h0000_33FC);
      apb(0, OFS_OVS, 0); chk(32'h0000_3221, rd);
      converterOn <= 1'b0;
      apb(1, OFS_OVS, 32'h0);
      apb(0, OFS_OVS, 0); chk(32'h0, rd);
      syncMode <= 1'b1;
      partnerConverterResult <= 16'hBEEF;
      @(posedge core_clk);
      partnerValid <= 1'b1;
      @(posedge core_clk);
      partnerValid <= 1'b0;
      apb(0, OFS_RESULT, 0); chk({16'hBEEF, 16'h0} | smp(5'h03, 2'h0), rd);
      finish_test();
   end
endmodule // asro_tb_top
